// file: src/bxc_params.svh
// constants for the bit, transfer and control execution unit
`ifndef BXC_PARAMS_SVH
`define BXC_PARAMS_SVH
`define BXC_FLAG_C 3'h0
`define BXC_FLAG_Z 3'h1
`define BXC_FLAG_N 3'h2
`define BXC_FLAG_V 3'h3
`define BXC_FLAG_S 3'h4
`define BXC_FLAG_H 3'h5
`define BXC_FLAG_T 3'h6
`define BXC_FLAG_I 3'h7
`define BXC_PTR_BASE 5'h1a
`define BXC_MAP_FLAGS 6'h20
`define BXC_MAP_SPL 6'h21
`define BXC_MAP_SPH 6'h22
`define BXC_FLAGS_RESET 8'h00
`define BXC_SP_RESET 16'h0000
`define BXC_CYC_ONE 8'h01
`define BXC_CYC_MEM 8'h02
`define BXC_CYC_CODE 8'h03
`define BXC_SPM_STALL 8
`endif

// file: src/bxc_pkg.sv
// types for the bit, transfer and control execution unit
package bxc_pkg;
  typedef enum logic [4:0] {
    OP_NOP = 5'b00000,
    OP_IO_BIT_SET = 5'b00001,
    OP_IO_BIT_CLEAR = 5'b00010,
    OP_SHL_LOG = 5'b00011,
    OP_SHR_LOG = 5'b00100,
    OP_ROT_LEFT = 5'b00101,
    OP_ROT_RIGHT = 5'b00110,
    OP_SHR_ARITH = 5'b00111,
    OP_TFLAG_STORE = 5'b01000,
    OP_TFLAG_LOAD = 5'b01001,
    OP_FLAG_SET = 5'b01010,
    OP_FLAG_CLEAR = 5'b01011,
    OP_IND_READ = 5'b01100,
    OP_IND_WRITE = 5'b01101,
    OP_DIR_READ = 5'b01110,
    OP_DIR_WRITE = 5'b01111,
    OP_CODE_READ = 5'b10000,
    OP_CODE_READ_R0 = 5'b10001,
    OP_CODE_WRITE = 5'b10010,
    OP_PUSH = 5'b10011,
    OP_POP = 5'b10100,
    OP_SLEEP = 5'b10101,
    OP_WD_RESTART = 5'b10110,
    OP_BREAK = 5'b10111
  } bxc_op_e;
  typedef enum logic [1:0] {
    AM_PLAIN = 2'b00,
    AM_POSTINC = 2'b01,
    AM_PREDEC = 2'b10,
    AM_DISP = 2'b11
  } bxc_am_e;
  typedef enum logic [1:0] {
    PTR_X = 2'b00,
    PTR_Y = 2'b01,
    PTR_Z = 2'b10
  } bxc_ptr_e;
  typedef enum logic {
    S_IDLE = 1'b0,
    S_RUN = 1'b1
  } bxc_state_e;
endpackage

// file: src/bxc_shift_unit.sv
// shift and rotate datapath with its flag results
`timescale 1ns/1ns
`default_nettype none
module bxc_shift_unit
  import bxc_pkg::*;
(
  input wire bxc_op_e op_i,
  input wire logic [7:0] d_i,
  input wire logic c_i,
  output logic [7:0] res_o,
  output logic c_o,
  output logic z_o,
  output logic n_o,
  output logic v_o
);
  always_comb begin
    res_o = d_i;
    c_o = c_i;
    case (op_i)
      OP_SHL_LOG: begin
        res_o = {d_i[6:0], 1'b0}; // RULE3
        c_o = d_i[7];
      end
      OP_ROT_LEFT: begin
        res_o = {d_i[6:0], c_i}; // RULE3
        c_o = d_i[7];
      end
      OP_SHR_LOG: begin
        res_o = {1'b0, d_i[7:1]}; // RULE4
        c_o = d_i[0];
      end
      OP_ROT_RIGHT: begin
        res_o = {c_i, d_i[7:1]}; // RULE4
        c_o = d_i[0];
      end
      OP_SHR_ARITH: begin
        res_o = {d_i[7], d_i[7:1]}; // RULE4
        c_o = d_i[0];
      end
      default: begin
        res_o = d_i;
        c_o = c_i;
      end
    endcase
    z_o = (res_o == 8'h00);
    n_o = res_o[7];
    v_o = res_o[7] ^ c_o;
  end
endmodule
`default_nettype wire

// file: src/bxc_ptr_step.sv
// pointer step: effective address and updated pointer, wrapping
`timescale 1ns/1ns
`default_nettype none
module bxc_ptr_step #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic [WIDTH-1:0] base_i,
  input wire logic pre_i,
  input wire logic step_i,
  input wire logic down_i,
  input wire logic [5:0] off_i,
  output logic [WIDTH-1:0] addr_o,
  output logic [WIDTH-1:0] next_o
);
  logic [WIDTH-1:0] stepped;
  // modulo arithmetic falls out of the fixed width
  assign stepped = down_i ? WIDTH'(base_i - 1'b1) : WIDTH'(base_i + 1'b1); // RULE21
  assign addr_o = pre_i ? stepped : WIDTH'(base_i + {{(WIDTH-6){1'b0}}, off_i});
  assign next_o = step_i ? stepped : base_i;
endmodule
`default_nettype wire

// file: src/bxc_core.sv
// execution unit for bit, shift, flag, transfer and control operations
// Operation
// RULE1: io bit set, flags kept, two cycles
// RULE2: io bit clear, flags kept, two cycles
// RULE3: left shift or rotate, ZCNV, one cycle
// RULE4: right shift, rotate, arithmetic; ZCNV, one cycle
// RULE5: store register bit into T only
// RULE6: load T into register bit, flags kept
// RULE7: each flag set/clear touches one flag
// RULE8: overflow clear zeroes V only
// RULE9: post-increment read, two cycles, flags kept
// RULE10: pre-decrement then read, two cycles
// RULE11: displacement read only on Y, Z
// RULE12: writes mirror read addressing forms, two cycles
// RULE13: direct read from embedded address, two cycles
// RULE14: direct write to embedded address, two cycles
// RULE15: code read via Z, three cycles, R0 default
// RULE16: push and pop, two cycles each
// RULE17: pop completes in two cycles, flags kept
// RULE18: sleep issues in one cycle, pulse out
// RULE19: watchdog restart pulse, one cycle
// RULE20: break is a debug pulse, flags kept
// RULE21: pointer steps wrap at sixteen bits
// RULE22: code write stalls, data from R1:R0
`timescale 1ns/1ns
`default_nettype none
`include "bxc_params.svh"
module bxc_core
  import bxc_pkg::*;
#(
  parameter int unsigned SPM_STALL = `BXC_SPM_STALL
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic op_valid_i,
  input wire bxc_op_e op_i,
  input wire bxc_am_e am_i,
  input wire bxc_ptr_e ptr_i,
  input wire logic [4:0] rd_i,
  input wire logic [2:0] bit_i,
  input wire logic [5:0] io_addr_i,
  input wire logic [5:0] disp_i,
  input wire logic [15:0] addr16_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic [15:0] dm_addr_o,
  output logic dm_re_o,
  output logic dm_we_o,
  output logic [7:0] dm_wdata_o,
  input wire logic [7:0] dm_rdata_i,
  output logic [5:0] io_addr_o,
  output logic io_re_o,
  output logic io_we_o,
  output logic [7:0] io_wdata_o,
  input wire logic [7:0] io_rdata_i,
  output logic [15:0] pm_addr_o,
  output logic pm_re_o,
  output logic pm_we_o,
  output logic [15:0] pm_wdata_o,
  input wire logic [7:0] pm_rdata_i,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o,
  output logic sleep_o,
  output logic wdr_o,
  output logic break_o
);
  logic [7:0] rf [0:31];
  logic [7:0] flags_reg;
  logic [15:0] sp_reg;
  bxc_state_e state_reg;
  logic [7:0] cnt_reg;
  bxc_op_e op_reg;
  logic [4:0] rd_reg;
  logic [2:0] bit_reg;
  logic accept, finish, is_mem, is_code, is_shift, illegal, ptr_upd;
  logic [7:0] cyc_sel, rd_val, sh_res;
  logic sh_c, sh_z, sh_n, sh_v;
  bxc_ptr_e ptr_sel;
  logic [4:0] ptr_lo;
  logic [15:0] ptr_val, ptr_addr, ptr_next, sp_addr, sp_next, eff_addr;
  logic [5:0] ptr_off;

  assign accept = op_valid_i && (state_reg == S_IDLE);
  assign finish = (state_reg == S_RUN) && (cnt_reg == 8'h00);
  assign rd_val = rf[rd_i];
  assign is_shift = (op_i == OP_SHL_LOG) || (op_i == OP_SHR_LOG) || (op_i == OP_ROT_LEFT)
    || (op_i == OP_ROT_RIGHT) || (op_i == OP_SHR_ARITH);
  assign is_mem = (op_i == OP_IND_READ) || (op_i == OP_IND_WRITE) || (op_i == OP_DIR_READ)
    || (op_i == OP_DIR_WRITE) || (op_i == OP_PUSH) || (op_i == OP_POP);
  assign is_code = (op_i == OP_CODE_READ) || (op_i == OP_CODE_READ_R0);
  // code read forces the Z pair whatever the decoder put on ptr_i
  assign ptr_sel = is_code || (op_i == OP_CODE_WRITE) ? PTR_Z : ptr_i; // RULE15
  assign ptr_lo = 5'(`BXC_PTR_BASE + {2'b00, ptr_sel, 1'b0});
  assign ptr_val = {rf[5'(ptr_lo + 5'h01)], rf[ptr_lo]};
  assign ptr_off = (am_i == AM_DISP) ? disp_i : 6'h00;
  // X has no displacement form; code read has only plain and post-increment
  assign illegal = (((op_i == OP_IND_READ) || (op_i == OP_IND_WRITE)) && (am_i == AM_DISP)
    && (ptr_i == PTR_X)) || (op_i == OP_CODE_READ && am_i[1]) // RULE11
    || (op_i == OP_CODE_READ_R0 && am_i != AM_PLAIN);
  assign ptr_upd = !illegal && ((op_i == OP_IND_READ) || (op_i == OP_IND_WRITE)
    || (op_i == OP_CODE_READ)) && ((am_i == AM_POSTINC) || (am_i == AM_PREDEC));

  bxc_shift_unit u_shift (
    .op_i(op_i),
    .d_i(rd_val),
    .c_i(flags_reg[`BXC_FLAG_C]),
    .res_o(sh_res),
    .c_o(sh_c),
    .z_o(sh_z),
    .n_o(sh_n),
    .v_o(sh_v)
  );

  bxc_ptr_step #(.WIDTH(16)) u_ptr (
    .base_i(ptr_val),
    .pre_i(am_i == AM_PREDEC), // RULE10
    .step_i(ptr_upd), // RULE9
    .down_i(am_i == AM_PREDEC),
    .off_i(ptr_off), // RULE11
    .addr_o(ptr_addr),
    .next_o(ptr_next)
  );

  // push writes then decrements, pop increments then reads
  bxc_ptr_step #(.WIDTH(16)) u_sp (
    .base_i(sp_reg),
    .pre_i(op_i == OP_POP),
    .step_i(1'b1),
    .down_i(op_i == OP_PUSH),
    .off_i(6'h00),
    .addr_o(sp_addr),
    .next_o(sp_next)
  );

  always_comb begin
    case (op_i)
      OP_DIR_READ, OP_DIR_WRITE: eff_addr = addr16_i; // RULE13 RULE14
      OP_PUSH, OP_POP: eff_addr = sp_addr; // RULE16
      default: eff_addr = ptr_addr;
    endcase
  end

  always_comb begin
    if (illegal) begin
      cyc_sel = `BXC_CYC_ONE;
    end else if (is_mem || (op_i == OP_IO_BIT_SET) || (op_i == OP_IO_BIT_CLEAR)) begin
      cyc_sel = `BXC_CYC_MEM; // RULE1 RULE2 RULE9 RULE12 RULE16 RULE17
    end else if (is_code) begin
      cyc_sel = `BXC_CYC_CODE; // RULE15
    end else if (op_i == OP_CODE_WRITE) begin
      cyc_sel = 8'(SPM_STALL); // RULE22
    end else begin
      cyc_sel = `BXC_CYC_ONE; // RULE18 RULE19 RULE20
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      busy_o <= 1'b0;
      cnt_reg <= 8'h00;
      op_reg <= OP_NOP;
      rd_reg <= 5'h00;
      bit_reg <= 3'h0;
    end else if (accept) begin
      op_reg <= op_i;
      rd_reg <= (op_i == OP_CODE_READ_R0) ? 5'h00 : rd_i; // RULE15
      bit_reg <= bit_i;
      if (cyc_sel != `BXC_CYC_ONE) begin
        state_reg <= S_RUN;
        busy_o <= 1'b1;
        cnt_reg <= 8'(cyc_sel - 8'h02);
      end
    end else if (finish) begin
      state_reg <= S_IDLE;
      busy_o <= 1'b0;
    end else if (state_reg == S_RUN) begin
      cnt_reg <= 8'(cnt_reg - 8'h01);
    end
  end

  // a host write in the same cycle as an execution write loses
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 32; i++) begin
        rf[i] <= 8'h00;
      end
    end else begin
      if (reg_wr_i && !reg_addr_i[5]) begin
        rf[reg_addr_i[4:0]] <= reg_wdata_i;
      end
      if (accept && is_shift) begin
        rf[rd_i] <= sh_res; // RULE3 RULE4
      end
      if (accept && op_i == OP_TFLAG_LOAD) begin
        rf[rd_i][bit_i] <= flags_reg[`BXC_FLAG_T]; // RULE6
      end
      if (accept && ptr_upd) begin
        rf[ptr_lo] <= ptr_next[7:0]; // RULE9 RULE10 RULE12
        rf[5'(ptr_lo + 5'h01)] <= ptr_next[15:8];
      end
      if (finish && ((op_reg == OP_IND_READ) || (op_reg == OP_DIR_READ)
          || (op_reg == OP_POP))) begin
        rf[rd_reg] <= dm_rdata_i; // RULE9 RULE13 RULE17
      end
      if (finish && ((op_reg == OP_CODE_READ) || (op_reg == OP_CODE_READ_R0))) begin
        rf[rd_reg] <= pm_rdata_i; // RULE15
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_reg <= `BXC_FLAGS_RESET;
    end else begin
      if (reg_wr_i && reg_addr_i == `BXC_MAP_FLAGS) begin
        flags_reg <= reg_wdata_i;
      end
      if (accept && is_shift) begin
        flags_reg[`BXC_FLAG_Z] <= sh_z; // RULE3 RULE4
        flags_reg[`BXC_FLAG_C] <= sh_c;
        flags_reg[`BXC_FLAG_N] <= sh_n;
        flags_reg[`BXC_FLAG_V] <= sh_v;
      end
      if (accept && op_i == OP_TFLAG_STORE) begin
        flags_reg[`BXC_FLAG_T] <= rd_val[bit_i]; // RULE5
      end
      if (accept && op_i == OP_FLAG_SET) begin
        flags_reg[bit_i] <= 1'b1; // RULE7
      end
      // the overflow clear arrives as flag clear with the V index
      if (accept && op_i == OP_FLAG_CLEAR) begin
        flags_reg[bit_i] <= 1'b0; // RULE7 RULE8
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sp_reg <= `BXC_SP_RESET;
    end else begin
      if (reg_wr_i && reg_addr_i == `BXC_MAP_SPL) begin
        sp_reg[7:0] <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `BXC_MAP_SPH) begin
        sp_reg[15:8] <= reg_wdata_i;
      end
      if (accept && ((op_i == OP_PUSH) || (op_i == OP_POP))) begin
        sp_reg <= sp_next; // RULE16
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dm_addr_o <= 16'h0000;
      dm_re_o <= 1'b0;
      dm_we_o <= 1'b0;
      dm_wdata_o <= 8'h00;
    end else if (accept && is_mem && !illegal) begin
      dm_addr_o <= eff_addr; // RULE9 RULE10 RULE11 RULE12 RULE13 RULE14
      dm_re_o <= (op_i == OP_IND_READ) || (op_i == OP_DIR_READ) || (op_i == OP_POP);
      dm_we_o <= (op_i == OP_IND_WRITE) || (op_i == OP_DIR_WRITE) || (op_i == OP_PUSH);
      dm_wdata_o <= rd_val; // RULE12 RULE14 RULE16
    end else if (finish) begin
      dm_re_o <= 1'b0;
      dm_we_o <= 1'b0;
    end
  end

  // read-modify-write: the write strobe follows once the core is free again
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      io_addr_o <= 6'h00;
      io_re_o <= 1'b0;
      io_we_o <= 1'b0;
      io_wdata_o <= 8'h00;
    end else if (accept && ((op_i == OP_IO_BIT_SET) || (op_i == OP_IO_BIT_CLEAR))) begin
      io_addr_o <= io_addr_i;
      io_re_o <= 1'b1;
      io_we_o <= 1'b0;
    end else if (finish && (op_reg == OP_IO_BIT_SET)) begin
      io_re_o <= 1'b0;
      io_we_o <= 1'b1;
      io_wdata_o <= io_rdata_i | (8'h01 << bit_reg); // RULE1
    end else if (finish && (op_reg == OP_IO_BIT_CLEAR)) begin
      io_re_o <= 1'b0;
      io_we_o <= 1'b1;
      io_wdata_o <= io_rdata_i & ~(8'h01 << bit_reg); // RULE2
    end else begin
      io_we_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pm_addr_o <= 16'h0000;
      pm_re_o <= 1'b0;
      pm_we_o <= 1'b0;
      pm_wdata_o <= 16'h0000;
    end else begin
      pm_re_o <= accept && is_code && !illegal;
      pm_we_o <= accept && (op_i == OP_CODE_WRITE);
      if (accept && !illegal && (is_code || op_i == OP_CODE_WRITE)) begin
        pm_addr_o <= ptr_val; // RULE15
        pm_wdata_o <= {rf[5'h01], rf[5'h00]}; // RULE22
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      sleep_o <= 1'b0;
      wdr_o <= 1'b0;
      break_o <= 1'b0;
    end else begin
      done_o <= (accept && cyc_sel == `BXC_CYC_ONE) || finish;
      illegal_o <= accept && illegal;
      sleep_o <= accept && (op_i == OP_SLEEP); // RULE18
      wdr_o <= accept && (op_i == OP_WD_RESTART); // RULE19
      break_o <= accept && (op_i == OP_BREAK); // RULE20
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 8'h00;
    end else if (!reg_addr_i[5]) begin
      reg_rdata_o <= rf[reg_addr_i[4:0]];
    end else begin
      case (reg_addr_i)
        `BXC_MAP_FLAGS: reg_rdata_o <= flags_reg;
        `BXC_MAP_SPL: reg_rdata_o <= sp_reg[7:0];
        `BXC_MAP_SPH: reg_rdata_o <= sp_reg[15:8];
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  a_io_set_write: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    (accept && op_i == OP_IO_BIT_SET) |=> io_re_o && busy_o ##1 io_we_o && done_o
    && io_wdata_o[$past(bit_reg)] && !busy_o)
    else $error("io bit set not written in two cycles");
  a_io_clr_write: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    (finish && op_reg == OP_IO_BIT_CLEAR) |=> io_we_o
    && io_wdata_o == ($past(io_rdata_i) & ~(8'h01 << $past(bit_reg))))
    else $error("io bit clear value wrong");
  a_shift_flags: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    (accept && op_i == OP_SHL_LOG && !reg_wr_i) |=>
    flags_reg[`BXC_FLAG_C] == $past(rd_val[7])
    && flags_reg[`BXC_FLAG_Z] == ($past(rd_val[6:0]) == 7'h00)
    && flags_reg[7:4] == $past(flags_reg[7:4]) && done_o)
    else $error("left shift flags wrong");
  a_asr_keep_top: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    (accept && op_i == OP_SHR_ARITH && !reg_wr_i) |=>
    flags_reg[`BXC_FLAG_C] == $past(rd_val[0]) && flags_reg[`BXC_FLAG_N] == $past(rd_val[7]))
    else $error("arithmetic right shift flags wrong");
  a_tflag_store: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    (accept && op_i == OP_TFLAG_STORE && !reg_wr_i) |=>
    flags_reg[`BXC_FLAG_T] == $past(rd_val[bit_i])
    && flags_reg[5:0] == $past(flags_reg[5:0]))
    else $error("transfer flag store wrong");
  a_vflag_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    (accept && op_i == OP_FLAG_CLEAR && bit_i == `BXC_FLAG_V && !reg_wr_i) |=>
    !flags_reg[`BXC_FLAG_V] && flags_reg[2:0] == $past(flags_reg[2:0])
    && flags_reg[7:4] == $past(flags_reg[7:4]))
    else $error("overflow clear touched other flags");
  a_mem_two_cycles: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9 RULE12
    (accept && is_mem && !illegal && !reg_wr_i) |=> busy_o && (dm_re_o || dm_we_o)
    && $stable(flags_reg) ##1 done_o && !busy_o && !dm_re_o && !dm_we_o)
    else $error("data memory access not two cycles");
  a_predec_addr: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10 RULE21
    (accept && op_i == OP_IND_READ && am_i == AM_PREDEC) |=>
    dm_addr_o == 16'($past(ptr_val) - 16'h0001))
    else $error("pre-decrement address wrong");
  a_disp_addr: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    (accept && op_i == OP_IND_READ && am_i == AM_DISP && ptr_i != PTR_X) |=>
    dm_addr_o == 16'($past(ptr_val) + {10'h000, $past(disp_i)}))
    else $error("displacement address wrong");
  a_code_three: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
    (accept && is_code && !illegal) |=> pm_re_o && busy_o ##1 !pm_re_o && busy_o
    ##1 done_o && !busy_o)
    else $error("code read not three cycles");
  a_wdr_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // RULE19
    (accept && op_i == OP_WD_RESTART) |=> wdr_o && done_o && !busy_o ##1 !wdr_o)
    else $error("watchdog restart pulse wrong");
  a_code_write_stall: assert property (@(posedge clk_i) disable iff (rst_i) // RULE22
    (accept && op_i == OP_CODE_WRITE) |=> pm_we_o && busy_o ##[1:300] done_o)
    else $error("code write stall wrong");
endmodule
`default_nettype wire

// file: sim/bxc_mem.sv
// data, io and code memory model on the far side of the execution unit
`timescale 1ns/1ns
`default_nettype none
module bxc_mem (
  input wire logic clk_i,
  input wire logic [15:0] dm_addr_i,
  input wire logic dm_re_i,
  input wire logic dm_we_i,
  input wire logic [7:0] dm_wdata_i,
  output logic [7:0] dm_rdata_o,
  input wire logic [5:0] io_addr_i,
  input wire logic io_re_i,
  input wire logic io_we_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic [15:0] pm_addr_i,
  input wire logic pm_re_i,
  input wire logic pm_we_i,
  input wire logic [15:0] pm_wdata_i,
  output logic [7:0] pm_rdata_o
);
  logic [7:0] dm [0:65535];
  logic [7:0] io [0:63];
  logic [7:0] dm_last = 8'h00;
  logic [7:0] io_last = 8'h00;
  logic [7:0] pm_byte = 8'h00;
  logic pm_valid = 1'b0;
  logic [15:0] pm_word;
  // outside a read the lines show the inverse of the last value, never a stale match
  assign dm_rdata_o = dm_re_i ? dm[dm_addr_i] : ~dm_last;
  assign io_rdata_o = io_re_i ? io[io_addr_i] : ~io_last;
  // code byte follows one cycle after the request; otherwise the inverse of the last byte
  assign pm_rdata_o = pm_valid ? pm_byte : ~pm_byte;
  always @(posedge clk_i) begin
    dm_last <= dm_rdata_o;
    io_last <= io_rdata_o;
    pm_valid <= pm_re_i;
    pm_byte <= pm_addr_i[7:0] ^ 8'h5a;
    if (dm_we_i) begin
      dm[dm_addr_i] <= dm_wdata_i;
    end
    if (io_we_i) begin
      io[io_addr_i] <= io_wdata_i;
    end
    if (pm_we_i) begin
      pm_word <= pm_wdata_i;
    end
  end
endmodule
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the bit, transfer and control execution unit
`timescale 1ns/1ns
`default_nettype none
module tb
  import bxc_pkg::*;
;
  localparam int STALL = 4;
  logic clk_i, rst_i, op_valid_i, reg_wr_i, reg_rd_i;
  bxc_op_e op_i;
  bxc_am_e am_i;
  bxc_ptr_e ptr_i;
  logic [4:0] rd_i;
  logic [2:0] bit_i;
  logic [5:0] io_addr_i, disp_i, reg_addr_i, io_addr_o;
  logic [15:0] addr16_i, dm_addr_o, pm_addr_o, pm_wdata_o;
  logic [7:0] reg_wdata_i, reg_rdata_o, dm_wdata_o, dm_rdata_i, io_wdata_o, io_rdata_i, pm_rdata_i;
  logic dm_re_o, dm_we_o, io_re_o, io_we_o, pm_re_o, pm_we_o;
  logic busy_o, done_o, illegal_o, sleep_o, wdr_o, break_o;
  int n_mismatch = 0;
  int samples_checked = 0;

  bxc_core #(.SPM_STALL(STALL)) bxc_core_i (.clk_i(clk_i), .rst_i(rst_i),
    .op_valid_i(op_valid_i), .op_i(op_i), .am_i(am_i), .ptr_i(ptr_i), .rd_i(rd_i),
    .bit_i(bit_i), .io_addr_i(io_addr_i), .disp_i(disp_i), .addr16_i(addr16_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .dm_addr_o(dm_addr_o),
    .dm_re_o(dm_re_o), .dm_we_o(dm_we_o), .dm_wdata_o(dm_wdata_o), .dm_rdata_i(dm_rdata_i),
    .io_addr_o(io_addr_o), .io_re_o(io_re_o), .io_we_o(io_we_o), .io_wdata_o(io_wdata_o),
    .io_rdata_i(io_rdata_i), .pm_addr_o(pm_addr_o), .pm_re_o(pm_re_o), .pm_we_o(pm_we_o),
    .pm_wdata_o(pm_wdata_o), .pm_rdata_i(pm_rdata_i), .busy_o(busy_o), .done_o(done_o),
    .illegal_o(illegal_o), .sleep_o(sleep_o), .wdr_o(wdr_o), .break_o(break_o));

  bxc_mem bxc_mem_i (.clk_i(clk_i), .dm_addr_i(dm_addr_o), .dm_re_i(dm_re_o),
    .dm_we_i(dm_we_o), .dm_wdata_i(dm_wdata_o), .dm_rdata_o(dm_rdata_i),
    .io_addr_i(io_addr_o), .io_re_i(io_re_o), .io_we_i(io_we_o), .io_wdata_i(io_wdata_o),
    .io_rdata_o(io_rdata_i), .pm_addr_i(pm_addr_o), .pm_re_i(pm_re_o), .pm_we_i(pm_we_o),
    .pm_wdata_i(pm_wdata_o), .pm_rdata_o(pm_rdata_i));

  always #20 clk_i = ~clk_i;

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hw(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic hr(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask

  // issue one operation, count cycles to done and check the pulse set {illegal,sleep,wdr,break}
  task automatic op(input bxc_op_e o, input bxc_am_e m, input bxc_ptr_e p, input logic [4:0] r,
      input logic [2:0] b, input logic [15:0] k, input int nc, input logic [3:0] pl);
    int n;
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_i <= o;
    am_i <= m;
    ptr_i <= p;
    rd_i <= r;
    bit_i <= b;
    io_addr_i <= k[5:0];
    disp_i <= k[5:0];
    addr16_i <= k;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    n = 1;
    #1;
    while (done_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(16'(n), 16'(nc));
    chk({illegal_o, sleep_o, wdr_o, break_o}, pl);
  endtask

  task automatic t_io;
    hw(6'h20, 8'ha5);
    bxc_mem_i.io[5] = 8'h40;
    op(OP_IO_BIT_SET, AM_PLAIN, PTR_X, 5'd0, 3'd3, 16'h0005, 2, 4'h0);
    // the io write strobe stands in the done cycle, so it lands one edge later
    @(posedge clk_i);
    #1;
    chk(bxc_mem_i.io[5], 8'h48);
    op(OP_IO_BIT_CLEAR, AM_PLAIN, PTR_X, 5'd0, 3'd6, 16'h0005, 2, 4'h0);
    @(posedge clk_i);
    #1;
    chk(bxc_mem_i.io[5], 8'h08);
    hr(6'h20, 8'ha5);
  endtask

  task automatic t_shift;
    bxc_op_e o[6] = '{OP_SHL_LOG, OP_SHL_LOG, OP_SHR_LOG, OP_ROT_LEFT, OP_ROT_RIGHT,
      OP_SHR_ARITH};
    logic [7:0] d[6] = '{8'h81, 8'h80, 8'h81, 8'h81, 8'h81, 8'h81};
    logic [7:0] f[6] = '{8'h11, 8'h10, 8'h11, 8'h11, 8'h11, 8'h10};
    logic [7:0] r[6] = '{8'h02, 8'h00, 8'h40, 8'h03, 8'hc0, 8'hc0};
    logic [7:0] g[6] = '{8'h19, 8'h1b, 8'h19, 8'h19, 8'h15, 8'h15};
    for (int i = 0; i < 6; i++) begin
      hw(6'h10, d[i]);
      hw(6'h20, f[i]);
      op(o[i], AM_PLAIN, PTR_X, 5'd16, 3'd0, 16'h0, 1, 4'h0);
      hr(6'h10, r[i]);
      hr(6'h20, g[i]);
    end
  endtask

  task automatic t_tbit;
    hw(6'h20, 8'h00);
    hw(6'h03, 8'h10);
    hw(6'h07, 8'h00);
    op(OP_TFLAG_STORE, AM_PLAIN, PTR_X, 5'd3, 3'd4, 16'h0, 1, 4'h0);
    hr(6'h20, 8'h40);
    op(OP_TFLAG_LOAD, AM_PLAIN, PTR_X, 5'd7, 3'd5, 16'h0, 1, 4'h0);
    hr(6'h07, 8'h20);
    hr(6'h20, 8'h40);
  endtask

  task automatic t_flag;
    for (int i = 0; i < 8; i++) begin
      hw(6'h20, 8'h00);
      op(OP_FLAG_SET, AM_PLAIN, PTR_X, 5'd0, 3'(i), 16'h0, 1, 4'h0);
      hr(6'h20, 8'h01 << i);
      hw(6'h20, 8'hff);
      op(OP_FLAG_CLEAR, AM_PLAIN, PTR_X, 5'd0, 3'(i), 16'h0, 1, 4'h0);
      hr(6'h20, ~(8'h01 << i));
    end
  endtask

  task automatic t_ld;
    hw(6'h20, 8'h5a);
    hw(6'd28, 8'hff);
    hw(6'd29, 8'hff);
    hw(6'd30, 8'h00);
    hw(6'd31, 8'h01);
    bxc_mem_i.dm[16'hffff] = 8'h3c;
    bxc_mem_i.dm[16'h0105] = 8'h77;
    op(OP_IND_READ, AM_POSTINC, PTR_Y, 5'd1, 3'd0, 16'h0, 2, 4'h0);
    hr(6'd1, 8'h3c);
    hr(6'd29, 8'h00);
    op(OP_IND_READ, AM_PREDEC, PTR_Y, 5'd2, 3'd0, 16'h0, 2, 4'h0);
    hr(6'd2, 8'h3c);
    hr(6'd28, 8'hff);
    op(OP_IND_READ, AM_DISP, PTR_Z, 5'd4, 3'd0, 16'h5, 2, 4'h0);
    hr(6'd4, 8'h77);
    hr(6'd30, 8'h00);
    op(OP_IND_READ, AM_DISP, PTR_X, 5'd5, 3'd0, 16'h5, 1, 4'h8);
    hr(6'd5, 8'h00);
    hr(6'h20, 8'h5a);
  endtask

  task automatic t_st;
    hw(6'd26, 8'h00);
    hw(6'd27, 8'h02);
    hw(6'd6, 8'h99);
    op(OP_IND_WRITE, AM_PLAIN, PTR_X, 5'd6, 3'd0, 16'h0, 2, 4'h0);
    op(OP_IND_WRITE, AM_PREDEC, PTR_X, 5'd6, 3'd0, 16'h0, 2, 4'h0);
    op(OP_IND_WRITE, AM_DISP, PTR_Z, 5'd6, 3'd0, 16'h2, 2, 4'h0);
    op(OP_DIR_WRITE, AM_PLAIN, PTR_X, 5'd6, 3'd0, 16'h0300, 2, 4'h0);
    op(OP_DIR_READ, AM_PLAIN, PTR_X, 5'd8, 3'd0, 16'h0105, 2, 4'h0);
    chk(bxc_mem_i.dm[16'h0200], 8'h99);
    chk(bxc_mem_i.dm[16'h01ff], 8'h99);
    chk(bxc_mem_i.dm[16'h0102], 8'h99);
    chk(bxc_mem_i.dm[16'h0300], 8'h99);
    hr(6'd8, 8'h77);
    hr(6'd26, 8'hff);
  endtask

  task automatic t_lpm;
    op(OP_CODE_READ_R0, AM_PLAIN, PTR_Z, 5'd9, 3'd0, 16'h0, 3, 4'h0);
    hr(6'd0, 8'h5a);
    op(OP_CODE_READ, AM_POSTINC, PTR_Z, 5'd9, 3'd0, 16'h0, 3, 4'h0);
    hr(6'd9, 8'h5a);
    op(OP_CODE_READ_R0, AM_POSTINC, PTR_Z, 5'd9, 3'd0, 16'h0, 1, 4'h8);
    hr(6'd30, 8'h01);
  endtask

  task automatic t_stk;
    hw(6'h21, 8'h10);
    hw(6'h22, 8'h00);
    op(OP_PUSH, AM_PLAIN, PTR_X, 5'd6, 3'd0, 16'h0, 2, 4'h0);
    chk(bxc_mem_i.dm[16'h0010], 8'h99);
    hr(6'h21, 8'h0f);
    op(OP_POP, AM_PLAIN, PTR_X, 5'd10, 3'd0, 16'h0, 2, 4'h0);
    hr(6'd10, 8'h99);
    hr(6'h21, 8'h10);
  endtask

  task automatic t_ctl;
    hw(6'h20, 8'h3c);
    hw(6'd1, 8'hc3);
    op(OP_SLEEP, AM_PLAIN, PTR_X, 5'd0, 3'd0, 16'h0, 1, 4'h4);
    op(OP_WD_RESTART, AM_PLAIN, PTR_X, 5'd0, 3'd0, 16'h0, 1, 4'h2);
    op(OP_BREAK, AM_PLAIN, PTR_X, 5'd0, 3'd0, 16'h0, 1, 4'h1);
    op(OP_CODE_WRITE, AM_PLAIN, PTR_Z, 5'd0, 3'd0, 16'h0, STALL, 4'h0);
    chk(bxc_mem_i.pm_word, 16'hc35a);
    hw(6'h30, 8'hff);
    hr(6'h30, 8'h00);
    hr(6'h20, 8'h3c);
  endtask

  // cuts a hang short well beyond the expected few hundred cycles
  initial begin
    #(40 * 20000);
    n_mismatch++;
    stop_test();
  end

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    op_valid_i = 1'b0;
    op_i = OP_NOP;
    am_i = AM_PLAIN;
    ptr_i = PTR_X;
    rd_i = 5'h00;
    bit_i = 3'h0;
    io_addr_i = 6'h00;
    disp_i = 6'h00;
    addr16_i = 16'h0000;
    reg_addr_i = 6'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_wdata_i = 8'h00;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_io();
    t_shift();
    t_tbit();
    t_flag();
    t_ld();
    t_st();
    t_lpm();
    t_stk();
    t_ctl();
    stop_test();
  end
endmodule
`default_nettype wire
